// >>> rtl/nest_pkg.sv
package nest_pkg;
   // source ranks, polling order low index first
   localparam int SRC_N       = 6;
   localparam int LVL_N       = 4;
   localparam int SRC_EXT0    = 0;
   localparam int SRC_TIMER0  = 1;
   localparam int SRC_EXT1    = 2;
   localparam int SRC_TIMER1  = 3;
   localparam int SRC_SERIAL  = 4;
   localparam int SRC_TIMER2  = 5;

   // code addresses of the service routines
   localparam logic [7:0] VEC_EXT0   = 8'h03;
   localparam logic [7:0] VEC_TIMER0 = 8'h0B;
   localparam logic [7:0] VEC_EXT1   = 8'h13;
   localparam logic [7:0] VEC_TIMER1 = 8'h1B;
   localparam logic [7:0] VEC_SERIAL = 8'h23;
   localparam logic [7:0] VEC_TIMER2 = 8'h2B;

   // register byte offsets
   localparam logic [7:0] OFF_ENABLE     = 8'h00;
   localparam logic [7:0] OFF_LEVEL      = 8'h04;
   localparam logic [7:0] OFF_EXT_MODE   = 8'h08;
   localparam logic [7:0] OFF_STATE      = 8'h0C;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h14;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

   // reset values and field layout
   localparam logic [7:0]  ENABLE_RST   = 8'h00;
   localparam logic [7:0]  ENABLE_MASK  = 8'hBF;
   localparam int          GLOBAL_BIT   = 7;
   localparam logic [11:0] LEVEL_RST    = 12'h000;
   localparam logic [1:0]  EXT_MODE_RST = 2'h0;
   localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

   // event bits of the interrupt status register
   localparam int EV_N      = 3;
   localparam int EV_VECTOR = 0;
   localparam int EV_NEST   = 1;
   localparam int EV_RETURN = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : nest_pkg

// >>> rtl/arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
   logic [5:0]  pend;
   logic [11:0] prio;
   logic [3:0]  in_service;
   logic        win_valid;
   logic [2:0]  win_idx;
   logic [1:0]  win_lvl;

   modport arbiter (input pend, prio, in_service, output win_valid, win_idx, win_lvl);
   modport ctrl    (output pend, prio, in_service, input win_valid, win_idx, win_lvl);
endinterface : arb_if
`default_nettype wire

// >>> rtl/level_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module level_arbiter (
   arb_if.arbiter bus
);
   logic [1:0] src_lvl [nest_pkg::SRC_N];
   logic [1:0] top_lvl;
   logic       busy;
   logic [5:0] eligible;

   genvar s;
   generate
      for (s = 0; s < nest_pkg::SRC_N; s++) begin : g_src
         assign src_lvl[s] = bus.prio[2*s +: 2];
         // only a strictly higher level than the one in service may cut in
         assign eligible[s] = bus.pend[s] & (~busy | (src_lvl[s] > top_lvl));
      end
   endgenerate

   assign busy = |bus.in_service;

   always_comb begin
      top_lvl = 2'h0;
      for (int l = 0; l < nest_pkg::LVL_N; l++) begin
         if (bus.in_service[l]) begin
            top_lvl = 2'(l);
         end
      end
   end

   // strictly greater keeps the lower rank on a tie
   always_comb begin
      bus.win_valid = 1'b0;
      bus.win_idx   = 3'h0;
      bus.win_lvl   = 2'h0;
      for (int i = 0; i < nest_pkg::SRC_N; i++) begin
         if (eligible[i] && (!bus.win_valid || src_lvl[i] > bus.win_lvl)) begin
            bus.win_valid = 1'b1;
            bus.win_idx   = 3'(i);
            bus.win_lvl   = src_lvl[i];
         end
      end
   end
endmodule : level_arbiter
`default_nettype wire

// >>> rtl/nested_priority_interrupt_unit.sv
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a request waits while an equal or higher level is in service
// - a higher-level request preempts a lower-level routine in service
// - after the preempting routine returns, the suspended lower routine resumes
// - ties resolve by polling rank 1 to 6; serial rank 5, 23H, flags kept
// - external input 0: rank 1, own request flag, vector 03H
// - external input 1: rank 3, own request flag, vector 13H
// - timer 2 overflow or trigger: rank 6, vector 2BH, flags kept
// - external flag cleared on vectoring only in transition mode
module nested_priority_interrupt_unit #(
   parameter int RET_W = 16
) (
   // clock and reset
   input  wire logic             clock_in,
   input  wire logic             nrst_in,
   // axi4-lite slave
   input  wire logic [7:0]       s_axi_awaddr_in,
   input  wire logic             s_axi_awvalid_in,
   output logic                  s_axi_awready_out,
   input  wire logic [31:0]      s_axi_wdata_in,
   input  wire logic [3:0]       s_axi_wstrb_in,
   input  wire logic             s_axi_wvalid_in,
   output logic                  s_axi_wready_out,
   output logic [1:0]            s_axi_bresp_out,
   output logic                  s_axi_bvalid_out,
   input  wire logic             s_axi_bready_in,
   input  wire logic [7:0]       s_axi_araddr_in,
   input  wire logic             s_axi_arvalid_in,
   output logic                  s_axi_arready_out,
   output logic [31:0]           s_axi_rdata_out,
   output logic [1:0]            s_axi_rresp_out,
   output logic                  s_axi_rvalid_out,
   input  wire logic             s_axi_rready_in,
   // request sources
   input  wire logic             ext0_n_in,
   input  wire logic             ext1_n_in,
   input  wire logic             timer_zero_overflow_flag_in,
   input  wire logic             timer_one_overflow_flag_in,
   input  wire logic             timer_two_overflow_flag_in,
   input  wire logic             timer_two_trigger_flag_in,
   input  wire logic             serial_receive_flag_in,
   input  wire logic             serial_transmit_flag_in,
   output logic                  timer_zero_clear_out,
   output logic                  timer_one_clear_out,
   // core sequencer
   output logic                  irq_req_out,
   output logic [7:0]            vector_out,
   output logic [1:0]            level_out,
   input  wire logic             vector_ack_in,
   input  wire logic [RET_W-1:0] return_addr_in,
   input  wire logic             reti_in,
   output logic                  resume_valid_out,
   output logic [RET_W-1:0]      resume_addr_out,
   output logic [3:0]            in_service_out,
   // event interrupt
   output logic                  irq_out
);
   arb_if arb ();
   level_arbiter u_arb (.bus(arb));

   // bus slave state
   logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic        aw_have_r, w_have_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   logic [31:0] rdata_r;
   // registers
   logic [7:0]  en_r;
   logic [11:0] prio_r;
   logic [1:0]  mode_r;
   logic [2:0]  irq_en_r, irq_stat_r;
   logic        irq_r;
   // sequencing state
   logic [1:0]  ext_flag_r, ext_prev_r;
   logic        req_r, clr_t0_r, clr_t1_r, resume_r;
   logic [2:0]  src_r;
   logic [7:0]  vector_r;
   logic [1:0]  level_r;
   logic [3:0]  in_service_r;
   logic [RET_W-1:0] resume_addr_r;
   logic [RET_W-1:0] ret_mem [nest_pkg::LVL_N];

   // bus decode
   wire         aw_take  = s_axi_awvalid_in & awready_r;
   wire         w_take   = s_axi_wvalid_in & wready_r;
   wire         ar_take  = s_axi_arvalid_in & arready_r;
   wire         do_write = aw_have_r & w_have_r & ~bvalid_r;
   wire [31:0]  wmask    = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [31:0]  wd       = wdata_r & wmask;
   wire         wr_en    = do_write & (awaddr_r == nest_pkg::OFF_ENABLE);
   wire         wr_lvl   = do_write & (awaddr_r == nest_pkg::OFF_LEVEL);
   wire         wr_mode  = do_write & (awaddr_r == nest_pkg::OFF_EXT_MODE);
   wire         wr_clr   = do_write & (awaddr_r == nest_pkg::OFF_IRQ_CLEAR);
   wire         wr_ien   = do_write & (awaddr_r == nest_pkg::OFF_IRQ_ENABLE);
   wire         wr_hit   = wr_en | wr_lvl | wr_mode | wr_clr | wr_ien;
   wire [7:0]   en_nxt   = ((en_r & ~wmask[7:0]) | wd[7:0]) & nest_pkg::ENABLE_MASK;
   wire [11:0]  prio_nxt = (prio_r & ~wmask[11:0]) | wd[11:0];
   wire [1:0]   mode_nxt = (mode_r & ~wmask[1:0]) | wd[1:0];
   wire [2:0]   ien_nxt  = (irq_en_r & ~wmask[2:0]) | wd[2:0];

   // sources in polling order, rank 1 at bit 0
   wire         t2_req   = timer_two_overflow_flag_in | timer_two_trigger_flag_in;
   wire         ser_req  = serial_receive_flag_in | serial_transmit_flag_in;
   wire [5:0]   pend_raw = {t2_req, ser_req, timer_one_overflow_flag_in, ext_flag_r[1],
                            timer_zero_overflow_flag_in, ext_flag_r[0]};
   // a timer flag is masked while its clear pulse is out, so it cannot vector twice
   wire [5:0]   in_clear = {2'b00, clr_t1_r, 1'b0, clr_t0_r, 1'b0};
   wire [5:0]   pend     = pend_raw & en_r[5:0] & {6{en_r[nest_pkg::GLOBAL_BIT]}} & ~in_clear;

   // rd decode from the live read address
   wire         rd_hit   = (s_axi_araddr_in == nest_pkg::OFF_ENABLE) |
                           (s_axi_araddr_in == nest_pkg::OFF_LEVEL) |
                           (s_axi_araddr_in == nest_pkg::OFF_EXT_MODE) |
                           (s_axi_araddr_in == nest_pkg::OFF_STATE) |
                           (s_axi_araddr_in == nest_pkg::OFF_IRQ_STATUS) |
                           (s_axi_araddr_in == nest_pkg::OFF_IRQ_ENABLE);
   wire [31:0]  rd_data  =
      (s_axi_araddr_in == nest_pkg::OFF_ENABLE)     ? {24'h0000_00, en_r} :
      (s_axi_araddr_in == nest_pkg::OFF_LEVEL)      ? {20'h0_0000, prio_r} :
      (s_axi_araddr_in == nest_pkg::OFF_EXT_MODE)   ? {30'h0000_0000, mode_r} :
      (s_axi_araddr_in == nest_pkg::OFF_STATE)      ? {20'h0_0000, ext_flag_r, pend_raw,
                                                       in_service_r} :
      (s_axi_araddr_in == nest_pkg::OFF_IRQ_STATUS) ? {29'h0000_0000, irq_stat_r} :
      (s_axi_araddr_in == nest_pkg::OFF_IRQ_ENABLE) ? {29'h0000_0000, irq_en_r} :
                                                      32'h0000_0000;

   // service nesting
   logic [1:0]  top_lvl;
   always_comb begin
      top_lvl = 2'h0;
      for (int l = 0; l < nest_pkg::LVL_N; l++) begin
         if (in_service_r[l]) begin
            top_lvl = 2'(l);
         end
      end
   end
   wire         busy      = |in_service_r;
   wire         ack       = vector_ack_in & req_r;
   wire         ret_go    = reti_in & busy;
   wire [3:0]   set_mask  = ack ? (4'h1 << level_r) : 4'h0;
   wire [3:0]   rel_mask  = ret_go ? (4'h1 << top_lvl) : 4'h0;
   wire [3:0]   svc_nxt   = (in_service_r & ~rel_mask) | set_mask;
   wire [7:0]   vector_nxt = nest_pkg::VEC_EXT0 + {2'b00, arb.win_idx, 3'b000};
   wire [2:0]   ev_set    = {ret_go, ack & busy, ack};
   wire [1:0]   ext_pin_n = {ext1_n_in, ext0_n_in};
   wire [1:0]   ext_ack   = {ack & (src_r == 3'(nest_pkg::SRC_EXT1)),
                             ack & (src_r == 3'(nest_pkg::SRC_EXT0))};

   assign arb.pend       = pend;
   assign arb.prio       = prio_r;
   assign arb.in_service = in_service_r;

   // external request flags, one per input
   genvar e;
   generate
      for (e = 0; e < 2; e++) begin : g_ext
         wire fall     = ext_prev_r[e] & ~ext_pin_n[e];
         // set wins over the vectoring clear; level mode simply follows the pin
         wire flag_nxt = mode_r[e] ? ((ext_flag_r[e] & ~ext_ack[e]) | fall) : ~ext_pin_n[e];
         always_ff @(posedge clock_in or negedge nrst_in) begin
            if (!nrst_in) begin
               ext_flag_r[e] <= 1'b0;
               ext_prev_r[e] <= 1'b1;
            end else begin
               ext_flag_r[e] <= flag_nxt;
               ext_prev_r[e] <= ext_pin_n[e];
            end
         end
      end
   endgenerate

   // axi write and read channels
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= nest_pkg::RESP_OKAY;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rresp_r   <= nest_pkg::RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
      end else begin
         if (aw_take) begin
            awaddr_r  <= s_axi_awaddr_in;
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
         end else if (do_write) begin
            aw_have_r <= 1'b0;
         end else if (bvalid_r && s_axi_bready_in) begin
            awready_r <= 1'b1;
         end
         if (w_take) begin
            wdata_r  <= s_axi_wdata_in;
            wstrb_r  <= s_axi_wstrb_in;
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
         end else if (do_write) begin
            w_have_r <= 1'b0;
         end else if (bvalid_r && s_axi_bready_in) begin
            wready_r <= 1'b1;
         end
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? nest_pkg::RESP_OKAY : nest_pkg::RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            bvalid_r <= 1'b0;
         end
         if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_data;
            rresp_r   <= rd_hit ? nest_pkg::RESP_OKAY : nest_pkg::RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready_in) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   // software registers and event status
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         en_r       <= nest_pkg::ENABLE_RST;
         prio_r     <= nest_pkg::LEVEL_RST;
         mode_r     <= nest_pkg::EXT_MODE_RST;
         irq_en_r   <= nest_pkg::IRQ_EN_RST;
         irq_stat_r <= 3'h0;
         irq_r      <= 1'b0;
      end else begin
         if (wr_en)   en_r     <= en_nxt;
         if (wr_lvl)  prio_r   <= prio_nxt;
         if (wr_mode) mode_r   <= mode_nxt;
         if (wr_ien)  irq_en_r <= ien_nxt;
         // an event in the clear cycle survives
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? wd[2:0] : 3'h0)) | ev_set;
         irq_r      <= |(irq_stat_r & irq_en_r);
      end
   end

   // request, vectoring and return
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         req_r         <= 1'b0;
         src_r         <= 3'h0;
         vector_r      <= 8'h00;
         level_r       <= 2'h0;
         in_service_r  <= 4'h0;
         clr_t0_r      <= 1'b0;
         clr_t1_r      <= 1'b0;
         resume_r      <= 1'b0;
         resume_addr_r <= '0;
      end else begin
         // the offer tracks the arbiter until taken; ack drops it for one cycle
         req_r        <= ~ack & arb.win_valid;
         if (!ack) begin
            src_r    <= arb.win_idx;
            vector_r <= vector_nxt;
            level_r  <= arb.win_lvl;
         end
         in_service_r <= svc_nxt;
         clr_t0_r     <= ack & (src_r == 3'(nest_pkg::SRC_TIMER0));
         clr_t1_r     <= ack & (src_r == 3'(nest_pkg::SRC_TIMER1));
         resume_r     <= ret_go;
         if (ret_go) resume_addr_r <= ret_mem[top_lvl];
      end
   end

   // one return slot per level: nesting never holds two routines of one level
   always_ff @(posedge clock_in) begin
      if (ack) ret_mem[level_r] <= return_addr_in;
   end

   assign s_axi_awready_out = awready_r;
   assign s_axi_wready_out  = wready_r;
   assign s_axi_bvalid_out  = bvalid_r;
   assign s_axi_bresp_out   = bresp_r;
   assign s_axi_arready_out = arready_r;
   assign s_axi_rvalid_out  = rvalid_r;
   assign s_axi_rresp_out   = rresp_r;
   assign s_axi_rdata_out   = rdata_r;
   assign timer_zero_clear_out = clr_t0_r;
   assign timer_one_clear_out  = clr_t1_r;
   assign irq_req_out      = req_r;
   assign vector_out       = vector_r;
   assign level_out        = level_r;
   assign resume_valid_out = resume_r;
   assign resume_addr_out  = resume_addr_r;
   assign in_service_out   = in_service_r;
   assign irq_out          = irq_r;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!nrst_in);

   wait_higher_a: assert property ((ack && busy) |-> level_r > top_lvl)
      else $error("vector taken at or below level in service");
   preempt_mark_a: assert property ((ack && !reti_in) |=>
      in_service_r == ($past(in_service_r) | (4'h1 << $past(level_r))))
      else $error("preempting level not marked");
   resume_lower_a: assert property ((ret_go && !ack) |=> resume_valid_out &&
      resume_addr_out == $past(ret_mem[top_lvl]) && !in_service_r[$past(top_lvl)])
      else $error("suspended routine not resumed");
   serial_vec_a: assert property ((req_r && src_r == 3'(nest_pkg::SRC_SERIAL)) |->
      vector_r == nest_pkg::VEC_SERIAL && !timer_zero_clear_out ##1 !timer_one_clear_out)
      else $error("serial vector wrong");
   ext0_vec_a: assert property ((req_r && src_r == 3'(nest_pkg::SRC_EXT0)) |->
      vector_r == nest_pkg::VEC_EXT0)
      else $error("external 0 vector wrong");
   timer0_clear_a: assert property ((req_r && src_r == 3'(nest_pkg::SRC_TIMER0)) |->
      (vector_r == nest_pkg::VEC_TIMER0) and (vector_ack_in |=> timer_zero_clear_out))
      else $error("timer 0 vector or clear wrong");
   ext1_vec_a: assert property ((req_r && src_r == 3'(nest_pkg::SRC_EXT1)) |->
      vector_r == nest_pkg::VEC_EXT1)
      else $error("external 1 vector wrong");
   timer1_clear_a: assert property ((req_r && src_r == 3'(nest_pkg::SRC_TIMER1)) |->
      (vector_r == nest_pkg::VEC_TIMER1) and (vector_ack_in |=> timer_one_clear_out))
      else $error("timer 1 vector or clear wrong");
   timer2_keep_a: assert property ((ack && src_r == 3'(nest_pkg::SRC_TIMER2)) |->
      vector_r == nest_pkg::VEC_TIMER2 ##1 (!timer_zero_clear_out && !timer_one_clear_out))
      else $error("timer 2 vector wrong or flag cleared");
   ext_level_a: assert property (!mode_r[0] |=> ext_flag_r[0] == !$past(ext0_n_in))
      else $error("level flag does not follow pin");
   ext_edge_clr_a: assert property ((mode_r[0] && ext_ack[0] && !g_ext[0].fall) |=>
      !ext_flag_r[0])
      else $error("transition flag not cleared on vectoring");
   save_return_a: assert property (ack |=> ret_mem[$past(level_r)] == $past(return_addr_in)
      && !irq_req_out)
      else $error("return address not saved");
endmodule : nested_priority_interrupt_unit
`default_nettype wire

// >>> tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        nrst_in,
   // offer from the unit
   input  wire logic        irq_req_in,
   input  wire logic [7:0]  vector_in,
   input  wire logic [15:0] ret_in,
   input  wire logic [1:0]  delay_in,
   output logic             ack_out,
   output logic [7:0]       vec_out,
   output logic [15:0]      ret_out,
   output logic [7:0]       acks_out,
   // timer flag sources
   input  wire logic        set0_in,
   input  wire logic        set1_in,
   input  wire logic        clr0_in,
   input  wire logic        clr1_in,
   output logic             t0_out,
   output logic             t1_out
);
   logic [1:0] wait_r;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         {ack_out, vec_out, ret_out, acks_out, t0_out, t1_out, wait_r} <= '0;
      end else begin
         // one ack per offer after a random stall, never twice in a row
         ack_out <= 1'b0;
         wait_r  <= 2'h0;
         if (irq_req_in && !ack_out) begin
            if (wait_r >= delay_in) ack_out <= 1'b1;
            else wait_r <= wait_r + 2'h1;
         end
         // record what the unit offered at the take edge
         if (ack_out && irq_req_in) begin
            vec_out  <= vector_in;
            ret_out  <= ret_in;
            acks_out <= acks_out + 8'h01;
         end
         // flag drops only at the edge that sees the clear pulse
         t0_out <= set0_in | (t0_out & !clr0_in);
         t1_out <= set1_in | (t1_out & !clr1_in);
      end
   end
endmodule : core_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clock, nrst, awv, wv, bry, arv, rry, e0n, e1n, t2o, t2t, srx, stx, reti, s0, s1;
   logic [7:0]  awa, ara;
   logic [31:0] wd, seed;
   logic [15:0] ra, r1;
   logic [1:0]  lseen;
   int          fails, cmp_count, cyc;
   wire logic   awr, wr_, bv, arr, rv, irq_req, vack, rvld, c0, c1, t0f, t1f, irq;
   wire logic [1:0]  br, rr, lvl;
   wire logic [31:0] rdat;
   wire logic [7:0]  vec, mvec, acks;
   wire logic [15:0] raddr, mret;
   wire logic [3:0]  insv;
   logic [7:0] offs [6] = '{nest_pkg::OFF_ENABLE, nest_pkg::OFF_LEVEL, nest_pkg::OFF_EXT_MODE,
                            nest_pkg::OFF_STATE, nest_pkg::OFF_IRQ_STATUS, nest_pkg::OFF_IRQ_ENABLE};

   nested_priority_interrupt_unit u_nested_priority_interrupt_unit (
      .clock_in(clock), .nrst_in(nrst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wr_), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
      .ext0_n_in(e0n), .ext1_n_in(e1n), .timer_zero_overflow_flag_in(t0f),
      .timer_one_overflow_flag_in(t1f), .timer_two_overflow_flag_in(t2o),
      .timer_two_trigger_flag_in(t2t), .serial_receive_flag_in(srx),
      .serial_transmit_flag_in(stx), .timer_zero_clear_out(c0), .timer_one_clear_out(c1),
      .irq_req_out(irq_req), .vector_out(vec), .level_out(lvl), .vector_ack_in(vack),
      .return_addr_in(ra), .reti_in(reti), .resume_valid_out(rvld), .resume_addr_out(raddr),
      .in_service_out(insv), .irq_out(irq));

   core_model u_core_model (
      .clock_in(clock), .nrst_in(nrst), .irq_req_in(irq_req), .vector_in(vec), .ret_in(ra),
      .delay_in(seed[18:17]), .ack_out(vack), .vec_out(mvec), .ret_out(mret), .acks_out(acks),
      .set0_in(s0), .set1_in(s1), .clr0_in(c0), .clr1_in(c1), .t0_out(t0f), .t1_out(t1f));

   function logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
   endfunction : xs

   function logic [7:0] exp_vec(input int i);
      exp_vec = 8'h03 + 8'(i * 8);
   endfunction : exp_vec

   task complete_run;
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : complete_run

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clock);
      awa <= a;
      wd  <= d;
      awv <= 1'b1;
      wv  <= 1'b1;
      bry <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (awr) awv <= 1'b0;
         if (wr_) wv <= 1'b0;
         if (bv) begin
            chk(br, er);
            bry <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axw

   task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic done;
      done = 1'b0;
      @(posedge clock);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      while (!done) begin
         @(posedge clock);
         if (arr) arv <= 1'b0;
         if (rv) begin
            chk(rdat, ed);
            chk(rr, er);
            rry <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axr

   task wait_ack;
      logic [7:0] n;
      n = acks;
      for (int k = 0; k < 400 && acks == n; k++) begin
         @(posedge clock);
         #1;
      end
      chk(acks != n, 1'b1);
   endtask : wait_ack

   task do_reti(input logic [15:0] er, input logic [3:0] eis);
      @(posedge clock);
      reti <= 1'b1;
      @(posedge clock);
      reti <= 1'b0;
      #1;
      chk(rvld, 1'b1);
      chk(raddr, er);
      chk(insv, eis);
   endtask : do_reti

   always #2.5 clock = ~clock;

   // random return addresses and ack stalls; hang guard
   always @(posedge clock) begin
      seed <= xs(seed);
      ra   <= seed[15:0];
      cyc  <= cyc + 1;
      // level offered at the take edge
      if (irq_req && vack) lseen <= lvl;
      if (cyc == 8000) begin
         fails++;
         complete_run;
      end
   end

   initial begin
      {clock, nrst, awv, wv, bry, arv, rry, t2o, t2t, srx, stx, reti, s0, s1} = '0;
      {awa, ara, wd, ra, fails, cmp_count, cyc} = '0;
      e0n  = 1'b1;
      e1n  = 1'b1;
      seed = 32'h0000_000F;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) axr(offs[i], 32'h0000_0000, nest_pkg::RESP_OKAY);
      axr(8'h1C, 32'h0000_0000, nest_pkg::RESP_SLVERR);
      axr(nest_pkg::OFF_IRQ_CLEAR, 32'h0000_0000, nest_pkg::RESP_SLVERR);
      axw(nest_pkg::OFF_STATE, 32'h0000_0FFF, nest_pkg::RESP_SLVERR);
      axw(nest_pkg::OFF_ENABLE, 32'hFFFF_FFFF, nest_pkg::RESP_OKAY);
      axr(nest_pkg::OFF_ENABLE, 32'h0000_00BF, nest_pkg::RESP_OKAY);
      axw(nest_pkg::OFF_IRQ_ENABLE, 32'h0000_0007, nest_pkg::RESP_OKAY);
      // all six at one level: level mode, then transition mode
      for (int p = 0; p < 2; p++) begin
         axw(nest_pkg::OFF_EXT_MODE, p ? 32'h0000_0003 : 32'h0000_0000, nest_pkg::RESP_OKAY);
         e0n <= 1'b0;
         e1n <= 1'b0;
         s0  <= 1'b1;
         s1  <= 1'b1;
         @(posedge clock);
         s0  <= 1'b0;
         s1  <= 1'b0;
         @(posedge clock);
         srx <= !p;
         stx <= p;
         t2o <= !p;
         t2t <= p;
         if (p) begin
            e0n <= 1'b1;
            e1n <= 1'b1;
         end
         for (int i = 0; i < 6; i++) begin
            wait_ack;
            chk(mvec, exp_vec(i));
            chk(insv, 4'b0001);
            chk(lseen, 2'h0);
            repeat (4) @(posedge clock);
            #1;
            chk(irq_req, 1'b0);
            case (i)
               0: e0n <= 1'b1;
               1: chk(t0f, 1'b0);
               2: e1n <= 1'b1;
               3: chk(t1f, 1'b0);
               4: {srx, stx} <= 2'b00;
               default: {t2o, t2t} <= 2'b00;
            endcase
            repeat (2) @(posedge clock);
            do_reti(mret, 4'b0000);
         end
      end
      chk(irq, 1'b1);
      axr(nest_pkg::OFF_IRQ_STATUS, 32'h0000_0005, nest_pkg::RESP_OKAY);
      axw(nest_pkg::OFF_IRQ_CLEAR, 32'h0000_0007, nest_pkg::RESP_OKAY);
      axw(nest_pkg::OFF_IRQ_ENABLE, 32'h0000_0002, nest_pkg::RESP_OKAY);
      // ext0 at level 1 preempted by timer 1 at level 3
      axw(nest_pkg::OFF_LEVEL, 32'h0000_00C1, nest_pkg::RESP_OKAY);
      axw(nest_pkg::OFF_EXT_MODE, 32'h0000_0001, nest_pkg::RESP_OKAY);
      e0n <= 1'b0;
      repeat (2) @(posedge clock);
      e0n <= 1'b1;
      wait_ack;
      chk(mvec, 8'h03);
      chk(lseen, 2'h1);
      chk(insv, 4'b0010);
      r1 = mret;
      repeat (3) @(posedge clock);
      #1;
      chk(irq, 1'b0);
      s1 <= 1'b1;
      @(posedge clock);
      s1 <= 1'b0;
      wait_ack;
      chk(mvec, 8'h1B);
      chk(lseen, 2'h3);
      chk(insv, 4'b1010);
      repeat (3) @(posedge clock);
      #1;
      chk(irq, 1'b1);
      do_reti(mret, 4'b0010);
      do_reti(r1, 4'b0000);
      repeat (4) @(posedge clock);
      #1;
      chk(irq_req, 1'b0);
      axr(nest_pkg::OFF_IRQ_STATUS, 32'h0000_0007, nest_pkg::RESP_OKAY);
      axw(nest_pkg::OFF_IRQ_CLEAR, 32'h0000_0002, nest_pkg::RESP_OKAY);
      axr(nest_pkg::OFF_IRQ_STATUS, 32'h0000_0005, nest_pkg::RESP_OKAY);
      chk(irq, 1'b0);
      complete_run;
   end
endmodule : tb_top
`default_nettype wire
